/* pcii_pkg.sv */
/*
  pcii_pkg: shared types and constants for the pulse catch and input
  interrupt block.
  assumes: single 125 MHz clock domain, no register bus.
*/
package pcii_pkg;
  localparam int NGRP = 4;
  localparam int LABEL_W = 16;
  localparam int MAX_NEST = 3;
  localparam logic [1:0] DEPTH_W0 = 2'h0;
  localparam logic [3:0] ALLOW_RST = 4'h0;
  localparam logic [3:0] ALLOW_RUN = 4'hF;
  localparam logic [3:0] SMALL_MASK = 4'h3;
  localparam logic [LABEL_W-1:0] LABEL_RST = 16'h0000;
  localparam int MIN_WIDTH_NS = 50000;
  localparam int CLK_NS = 8;
  localparam int MIN_WIDTH_CYC = (MIN_WIDTH_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {PCII_RISE, PCII_FALL, PCII_BOTH} pcii_edge_t;

  typedef struct packed {
    logic [NGRP-1:0] set_en;
    logic [NGRP-1:0] clr_en;
    logic timer_set;
    logic timer_clr;
  } pcii_mask_cmd_t;

  typedef struct packed {
    logic call;
    logic ret;
    logic routine_return;
  } pcii_exec_t;
endpackage : pcii_pkg

/* pcii_top.sv */
/*
  pcii_top: catch input flags and external input interrupt controller.
  assumes: inputs synchronous to clk; the execution engine pulses
  scan_end_pulse once per scan and acknowledges service by routine_return.
*/
`timescale 1ns/1ns
// What this block does
// - a captured pulse raises its group flag for exactly one scan
// - only the first qualifying pulse per scan is registered, the rest dropped
// - catch inputs bypass the noise filter entirely
// - catch inputs exist on groups 2 to 5, each with its own flag
// - each catch group selects rising or falling edge
// - the small variant drops the two highest groups for catch and interrupt
// - an enabled event pauses the main program and runs the routine
// - each interrupt input triggers on rising, falling or both edges
// - at most four interrupt sources, groups 2 to 5, none on group 1
// - each source has a writable jump label used on its interrupt
// - a read-only flag shows each source allowed or prohibited
// - mask and unmask commands clear or set each enable, timer included
// - entering run sets every interrupt enable to allowed
// - simultaneous pending sources are serviced group 2 first through 5
// - no preemption; arrivals during service wait until it completes
// - nesting beyond three calls in a routine flags an execution error
// - interrupts work only under the ladder language
// - immediate refresh moves inputs and outputs together during a routine
module pcii_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw inputs of groups 2..5, unfiltered
  input wire logic [3:0] grp_in,
  // configuration
  input wire logic [3:0] catch_sel,
  input wire logic [3:0] catch_fall,
  input wire logic [3:0] irq_sel,
  input wire pcii_pkg::pcii_edge_t irq_edge [4],
  input wire logic small_variant,
  input wire logic ladder_lang,
  // scan and run state
  input wire logic running_flag,
  input wire logic scan_end_pulse,
  // program commands
  input wire pcii_pkg::pcii_mask_cmd_t mask_cmd,
  input wire logic [3:0] label_we,
  input wire logic [pcii_pkg::LABEL_W-1:0] label_wdata,
  input wire pcii_pkg::pcii_exec_t exec_cmd,
  input wire logic immediate_io_refresh,
  input wire logic [3:0] out_image,
  // status outputs
  output logic [3:0] pulse_caught,
  output logic [3:0] irq_allowed,
  output logic timer_irq_allowed,
  output logic [pcii_pkg::LABEL_W-1:0] irq_label [4],
  // execution engine handshake
  output logic main_paused,
  output logic [1:0] active_src,
  output logic [pcii_pkg::LABEL_W-1:0] jump_label,
  output logic nest_error,
  output logic [3:0] refreshed_in,
  output logic [3:0] phys_out
);
  logic [3:0] in_prev_r;
  logic [3:0] avail;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] catch_hit;
  logic [3:0] irq_hit;
  logic [3:0] seen_r;
  logic [3:0] flag_nxt;
  logic [3:0] pend_r;
  logic [1:0] depth_r;
  logic run_prev_r;
  logic [1:0] pick;
  logic pick_ok;

  typedef enum logic {PCII_IDLE, PCII_SERV} pcii_state_t;
  pcii_state_t state_r;

  // small variant loses the top two groups
  assign avail = small_variant ? pcii_pkg::SMALL_MASK : 4'hF;

  // raw pin edges, no filter in the path
  assign rise = grp_in & ~in_prev_r;
  assign fall = ~grp_in & in_prev_r;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      catch_hit[i] = catch_sel[i] & avail[i] & (catch_fall[i] ? fall[i] : rise[i]);
      case (irq_edge[i])
        pcii_pkg::PCII_RISE: irq_hit[i] = rise[i];
        pcii_pkg::PCII_FALL: irq_hit[i] = fall[i];
        pcii_pkg::PCII_BOTH: irq_hit[i] = rise[i] | fall[i];
        default: irq_hit[i] = 1'b0;
      endcase
      irq_hit[i] = irq_hit[i] & irq_sel[i] & avail[i] & ladder_lang & running_flag;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      in_prev_r <= 4'h0;
    else
      in_prev_r <= grp_in;
  end

  // first pulse in a scan is kept; later ones only see seen_r set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      seen_r <= 4'h0;
    else if (scan_end_pulse)
      seen_r <= 4'h0;
    else
      seen_r <= seen_r | catch_hit;
  end

  // flag image updates at scan end so it stands a whole scan
  assign flag_nxt = seen_r | catch_hit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pulse_caught <= 4'h0;
    else if (scan_end_pulse)
      pulse_caught <= flag_nxt;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_prev_r <= 1'b0;
    else
      run_prev_r <= running_flag;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_allowed <= pcii_pkg::ALLOW_RST;
      timer_irq_allowed <= 1'b0;
    end
    else if (running_flag && !run_prev_r)
    begin
      irq_allowed <= pcii_pkg::ALLOW_RUN;
      timer_irq_allowed <= 1'b1;
    end
    else
    begin
      irq_allowed <= (irq_allowed & ~mask_cmd.clr_en) | mask_cmd.set_en;
      timer_irq_allowed <= (timer_irq_allowed & ~mask_cmd.timer_clr) | mask_cmd.timer_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < 4; i++)
        irq_label[i] <= pcii_pkg::LABEL_RST;
    else
      for (int i = 0; i < 4; i++)
        if (label_we[i])
          irq_label[i] <= label_wdata;
  end

  // lowest group index wins
  always_comb
  begin
    pick = 2'd0;
    pick_ok = 1'b0;
    for (int i = 3; i >= 0; i--)
      if (pend_r[i])
      begin
        pick = 2'(i);
        pick_ok = 1'b1;
      end
  end

  // disabled sources never latch, so re-enabling cannot fire stale events
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_r <= 4'h0;
    else if (!running_flag)
      pend_r <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        // a fresh allowed event wins; a blocked one must not keep a serviced bit alive
        if (irq_hit[i] && irq_allowed[i])
          pend_r[i] <= 1'b1;
        else if (state_r == PCII_IDLE && pick_ok && pick == 2'(i))
          pend_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= PCII_IDLE;
      main_paused <= 1'b0;
      active_src <= 2'd0;
      jump_label <= pcii_pkg::LABEL_RST;
    end
    else
    begin
      case (state_r)
        PCII_IDLE:
          if (pick_ok && running_flag)
          begin
            state_r <= PCII_SERV;
            main_paused <= 1'b1;
            active_src <= pick;
            jump_label <= irq_label[pick];
          end
        PCII_SERV:
          if (exec_cmd.routine_return || !running_flag)
          begin
            state_r <= PCII_IDLE;
            main_paused <= 1'b0;
          end
        default:
        begin
          state_r <= PCII_IDLE;
          main_paused <= 1'b0;
        end
      endcase
    end
  end

  // nesting counter inside a routine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      depth_r <= pcii_pkg::DEPTH_W0;
      nest_error <= 1'b0;
    end
    else if (state_r != PCII_SERV)
    begin
      depth_r <= pcii_pkg::DEPTH_W0;
      nest_error <= 1'b0;
    end
    else if (exec_cmd.call)
    begin
      if (depth_r == 2'(pcii_pkg::MAX_NEST))
        nest_error <= 1'b1;
      else
        depth_r <= depth_r + 2'd1;
    end
    else if (exec_cmd.ret && depth_r != pcii_pkg::DEPTH_W0)
      depth_r <= depth_r - 2'd1;
  end

  // immediate refresh only acts while a routine runs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshed_in <= 4'h0;
      phys_out <= 4'h0;
    end
    else if (immediate_io_refresh && state_r == PCII_SERV)
    begin
      refreshed_in <= grp_in;
      phys_out <= out_image;
    end
  end

  property p_flag_holds;
    @(posedge clk) disable iff (!rst_n)
    !scan_end_pulse |=> $stable(pulse_caught);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag changed mid scan");

  property p_small_no_catch;
    @(posedge clk) disable iff (!rst_n)
    small_variant |-> !catch_hit[3] && !catch_hit[2] && !irq_hit[3] && !irq_hit[2];
  endproperty
  a_small_no_catch: assert property (p_small_no_catch) else $error("small variant hit");

  property p_run_enable;
    @(posedge clk) disable iff (!rst_n)
    $rose(running_flag) |=> (irq_allowed == pcii_pkg::ALLOW_RUN) && timer_irq_allowed;
  endproperty
  a_run_enable: assert property (p_run_enable) else $error("enables not set on run");

  property p_no_preempt;
    @(posedge clk) disable iff (!rst_n)
    (state_r == PCII_SERV) && !exec_cmd.routine_return && running_flag |=> $stable(active_src);
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("preempted");

  property p_priority;
    @(posedge clk) disable iff (!rst_n)
    (state_r == PCII_IDLE) && running_flag && pend_r[0] |=> active_src == 2'd0 && main_paused;
  endproperty
  a_priority: assert property (p_priority) else $error("group 2 not first");

  property p_nest;
    @(posedge clk) disable iff (!rst_n)
    (state_r == PCII_SERV) && depth_r == 2'd3 && exec_cmd.call |=> nest_error;
  endproperty
  a_nest: assert property (p_nest) else $error("nest overflow missed");

  property p_ladder_only;
    @(posedge clk) disable iff (!rst_n)
    !ladder_lang |-> irq_hit == 4'h0;
  endproperty
  a_ladder_only: assert property (p_ladder_only) else $error("irq without ladder");

  property p_disabled_drop;
    @(posedge clk) disable iff (!rst_n)
    !pend_r[0] && !irq_allowed[0] |=> !pend_r[0];
  endproperty
  a_disabled_drop: assert property (p_disabled_drop) else $error("disabled latched");

  property p_mask_clear;
    @(posedge clk) disable iff (!rst_n)
    mask_cmd.clr_en[0] && !mask_cmd.set_en[0] && run_prev_r && running_flag
      |=> !irq_allowed[0];
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask not cleared");

  property p_refresh_idle;
    @(posedge clk) disable iff (!rst_n)
    state_r != PCII_SERV |=> $stable(phys_out) && $stable(refreshed_in);
  endproperty
  a_refresh_idle: assert property (p_refresh_idle) else $error("refresh outside routine");

  property p_return_release;
    @(posedge clk) disable iff (!rst_n)
    (state_r == PCII_SERV) && exec_cmd.routine_return |=> !main_paused;
  endproperty
  a_return_release: assert property (p_return_release) else $error("main not resumed");

  property p_label_jump;
    @(posedge clk) disable iff (!rst_n)
    (state_r == PCII_IDLE) && pick_ok && running_flag
      |=> main_paused && (jump_label == $past(irq_label[pick]));
  endproperty
  a_label_jump: assert property (p_label_jump) else $error("wrong jump label");
endmodule : pcii_top

/* pcii_sensor.sv */
/*
  pcii_sensor: external switch and sensor lines on groups 2..5.
  assumes: the bench calls set_lvl; lines change off the falling edge.
*/
`timescale 1ns/1ns
module pcii_sensor (
  // clock
  input wire logic clk,
  // input lines
  output logic [3:0] grp_in
);
  initial grp_in = 4'h0;
  // each level is held far beyond the routine time, so events stay apart
  task automatic set_lvl(input logic [3:0] v);
    @(negedge clk);
    grp_in = v;
    repeat (pcii_pkg::MIN_WIDTH_CYC) @(negedge clk);
  endtask : set_lvl
endmodule : pcii_sensor

/* pcii_top_bench.sv */
/*
  pcii_top_bench: self-checking bench for pcii_top.
  assumes: pcii_pkg and pcii_sensor compiled first; 125 MHz clock.
*/
`timescale 1ns/1ns
module pcii_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] grp_in;
  logic [3:0] catch_sel = 4'hF;
  logic [3:0] catch_fall = 4'h2;
  logic [3:0] irq_sel = 4'h0;
  pcii_pkg::pcii_edge_t irq_edge [4];
  logic ladder_lang = 1'b1;
  logic small_variant = 1'b0;
  logic immediate_io_refresh = 1'b0;
  logic [3:0] out_image = 4'h0;
  logic running_flag = 1'b0;
  logic scan_end_pulse = 1'b0;
  pcii_pkg::pcii_mask_cmd_t mask_cmd = '0;
  logic [3:0] label_we = 4'h0;
  logic [15:0] label_wdata = 16'h0000;
  pcii_pkg::pcii_exec_t exec_cmd = '0;
  logic [3:0] pulse_caught;
  logic [3:0] irq_allowed;
  logic [15:0] irq_label [4];
  logic main_paused;
  logic [1:0] active_src;
  logic [15:0] jump_label;
  logic nest_error;
  logic timer_irq_allowed;
  logic [3:0] refreshed_in;
  logic [3:0] phys_out;
  int failures = 0;
  int check_count = 0;

  always #4 clk = ~clk;
  initial irq_edge = '{pcii_pkg::PCII_RISE, pcii_pkg::PCII_FALL, pcii_pkg::PCII_BOTH,
    pcii_pkg::PCII_RISE};

  pcii_sensor pcii_sensor_i (.clk(clk), .grp_in(grp_in));

  pcii_top pcii_top_i (
    .clk(clk), .rst_n(rst_n), .grp_in(grp_in), .catch_sel(catch_sel),
    .catch_fall(catch_fall), .irq_sel(irq_sel), .irq_edge(irq_edge),
    .small_variant(small_variant), .ladder_lang(ladder_lang), .running_flag(running_flag),
    .scan_end_pulse(scan_end_pulse), .mask_cmd(mask_cmd), .label_we(label_we),
    .label_wdata(label_wdata), .exec_cmd(exec_cmd),
    .immediate_io_refresh(immediate_io_refresh),
    .out_image(out_image), .pulse_caught(pulse_caught), .irq_allowed(irq_allowed),
    .timer_irq_allowed(timer_irq_allowed), .irq_label(irq_label), .main_paused(main_paused),
    .active_src(active_src), .jump_label(jump_label), .nest_error(nest_error),
    .refreshed_in(refreshed_in), .phys_out(phys_out)
  );

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one-cycle command pulse, then three cycles for the registered effect
  task automatic cmd(input pcii_pkg::pcii_exec_t e, input pcii_pkg::pcii_mask_cmd_t m);
    @(negedge clk);
    exec_cmd = e;
    mask_cmd = m;
    @(negedge clk);
    exec_cmd = '0;
    mask_cmd = '0;
    repeat (3) @(negedge clk);
  endtask : cmd

  task automatic scan();
    @(negedge clk);
    scan_end_pulse = 1'b1;
    @(negedge clk);
    scan_end_pulse = 1'b0;
    @(negedge clk);
  endtask : scan

  task automatic t_catch();
    pcii_sensor_i.set_lvl(4'hE);
    scan();
    chk("caught", 4'hC, pulse_caught);
    pcii_sensor_i.set_lvl(4'h1);
    scan();
    chk("caught", 4'h3, pulse_caught);
    scan();
    chk("caught", 4'h0, pulse_caught);
    pcii_sensor_i.set_lvl(4'h0);
    $display("test catch finished");
  endtask : t_catch

  task automatic t_prio();
    catch_sel = 4'h0;
    irq_sel = 4'hF;
    for (int g = 0; g < 4; g++)
    begin
      @(negedge clk);
      label_we = 4'h1 << g;
      label_wdata = 16'h0010 + 16'(g);
    end
    @(negedge clk);
    label_we = 4'h0;
    @(negedge clk);
    chk("label3", 16'h0013, irq_label[3]);
    pcii_sensor_i.set_lvl(4'h5);
    chk("paused", 16'h0001, {15'h0000, main_paused});
    chk("src", 16'h0000, {14'h0000, active_src});
    chk("jump", 16'h0010, jump_label);
    cmd('{call: 1'b0, ret: 1'b0, routine_return: 1'b1}, '0);
    chk("src", 16'h0002, {14'h0000, active_src});
    chk("jump", 16'h0012, jump_label);
    cmd('{call: 1'b0, ret: 1'b0, routine_return: 1'b1}, '0);
    chk("paused", 16'h0000, {15'h0000, main_paused});
    pcii_sensor_i.set_lvl(4'h0);
    chk("paused", 16'h0001, {15'h0000, main_paused});
    chk("src", 16'h0002, {14'h0000, active_src});
    chk("jump", 16'h0012, jump_label);
    cmd('{call: 1'b0, ret: 1'b0, routine_return: 1'b1}, '0);
    $display("test priority finished");
  endtask : t_prio

  task automatic t_mask();
    cmd('0, '{set_en: 4'h0, clr_en: 4'h1, timer_set: 1'b0, timer_clr: 1'b1});
    chk("allowed", 16'h000E, {12'h000, irq_allowed});
    chk("timer", 16'h0000, {15'h0000, timer_irq_allowed});
    pcii_sensor_i.set_lvl(4'h1);
    chk("paused", 16'h0000, {15'h0000, main_paused});
    cmd('0, '{set_en: 4'h1, clr_en: 4'h0, timer_set: 1'b1, timer_clr: 1'b0});
    chk("allowed", 16'h000F, {12'h000, irq_allowed});
    chk("timer", 16'h0001, {15'h0000, timer_irq_allowed});
    chk("paused", 16'h0000, {15'h0000, main_paused});
    pcii_sensor_i.set_lvl(4'h0);
    $display("test mask finished");
  endtask : t_mask

  task automatic t_nest();
    pcii_sensor_i.set_lvl(4'h1);
    for (int n = 0; n < 3; n++)
      cmd('{call: 1'b1, ret: 1'b0, routine_return: 1'b0}, '0);
    chk("nest", 16'h0000, {15'h0000, nest_error});
    cmd('{call: 1'b1, ret: 1'b0, routine_return: 1'b0}, '0);
    chk("nest", 16'h0001, {15'h0000, nest_error});
    refresh(4'hA);
    chk("out", 16'h000A, {12'h000, phys_out});
    chk("in", 16'h0001, {12'h000, refreshed_in});
    cmd('{call: 1'b0, ret: 1'b0, routine_return: 1'b1}, '0);
    refresh(4'h5);
    chk("out", 16'h000A, {12'h000, phys_out});
    ladder_lang = 1'b0;
    pcii_sensor_i.set_lvl(4'h0);
    pcii_sensor_i.set_lvl(4'h1);
    chk("paused", 16'h0000, {15'h0000, main_paused});
    $display("test nest and language finished");
  endtask : t_nest

  // one-cycle refresh strobe carrying a new output image
  task automatic refresh(input logic [3:0] img);
    @(negedge clk);
    out_image = img;
    immediate_io_refresh = 1'b1;
    @(negedge clk);
    immediate_io_refresh = 1'b0;
    @(negedge clk);
  endtask : refresh

  // ladder back on, so only the variant mask can hold groups 4 and 5 quiet
  task automatic t_small();
    @(negedge clk);
    small_variant = 1'b1;
    ladder_lang = 1'b1;
    catch_sel = 4'hF;
    pcii_sensor_i.set_lvl(4'hD);
    chk("paused", 16'h0000, {15'h0000, main_paused});
    scan();
    chk("caught", 16'h0000, {12'h000, pulse_caught});
    $display("test small variant finished");
  endtask : t_small

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // whole run is about 70000 cycles
  initial
  begin
    repeat (95000) @(posedge clk);
    failures++;
    close_out();
  end

  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    running_flag = 1'b1;
    repeat (3) @(negedge clk);
    chk("allowed", 16'h000F, {12'h000, irq_allowed});
    chk("timer", 16'h0001, {15'h0000, timer_irq_allowed});
    t_catch();
    t_prio();
    t_mask();
    t_nest();
    t_small();
    close_out();
  end
endmodule : pcii_top_bench
